// ### core/irq_dispatch_regs.svh
// Purpose: named constants for the vectored interrupt dispatch block
// Assumes: 32-bit AXI4-Lite register words, 15-bit program counter
// Notes:   offsets are byte addresses
`ifndef IRQ_DISPATCH_REGS_SVH
`define IRQ_DISPATCH_REGS_SVH

`define NUM_SRC          12
`define PC_W             15
`define OFS_ENABLE       8'h00
`define OFS_PENDING      8'h04
`define OFS_STATUS_WORD  8'h08
`define OFS_PEND_SET     8'h0c
`define STAT_IRQ_EN_BIT  0
`define STAT_TRAP_BIT    1
`define STAT_BUSY_BIT    2
`define ENTRY_ADDR       15'h00ff
`define ACK_CYCLES       3'h7
`define ACK_LAST         3'h6
`define VEC_TRAP         8'hfe
`define VEC_DEFAULT      8'he0
`define PAGE_LAST        8'hff
`define PAGE_ONE         7'h01
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
// table slot of each maskable source, source 0 ranks highest;
// vector low byte is e0 plus twice the slot
`define SRC_SLOTS {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, \
                   4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd}

`endif

// ### core/irq_dispatch_pkg.sv
// Purpose: types shared by the vectored interrupt dispatch block
// Assumes: included constants header
// Notes:   source order follows arbitration rank, highest first
package irq_dispatch_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACK,
    ST_VEC_HI,
    ST_VEC_LO
  } disp_state_e;

  // bit index of each maskable source in enable and pending words
  typedef enum logic [3:0] {
    SRC_EXTERNAL_IRQ_PIN,
    SRC_IDLE_TIMER,
    SRC_TIMER1_CAPTURE_A,
    SRC_TIMER1_CAPTURE_B,
    SRC_SYNC_SERIAL,
    SRC_USART_RX,
    SRC_USART_TX,
    SRC_TIMER2_CAPTURE_A,
    SRC_TIMER2_CAPTURE_B,
    SRC_TIMER3_CAPTURE_A,
    SRC_TIMER3_CAPTURE_B,
    SRC_PORT_WAKE
  } src_id_e;

endpackage : irq_dispatch_pkg

// ### core/vectored_interrupt_dispatch.sv
// Purpose: interrupt gating, acknowledge sequence and vectored dispatch
// Assumes: core strobes are one-cycle pulses on aclk; program memory
//          answers a byte read one cycle after the request
// Notes:   one instruction cycle is one aclk cycle here
`timescale 1ns/100ps
`include "irq_dispatch_regs.svh"

module vectored_interrupt_dispatch
  import irq_dispatch_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [`NUM_SRC-1:0]   src_event,
  input  wire logic                  instr_start,
  input  wire logic                  instr_skipped,
  input  wire logic                  boot_exec,
  input  wire logic [`PC_W-1:0]      next_pc,
  input  wire logic                  trap_opcode,
  input  wire logic                  clear_trap_pending_instruction,
  input  wire logic                  return_and_reenable_instruction,
  input  wire logic                  vector_dispatch_instruction,
  input  wire logic [`PC_W-1:0]      dispatch_pc,
  input  wire logic [7:0]            mem_rd_data,
  output logic                       ack_busy,
  output logic                       push_valid,
  output logic [`PC_W-1:0]           push_addr,
  output logic                       pop_req,
  output logic                       pc_load,
  output logic [`PC_W-1:0]           pc_value,
  output logic                       mem_rd_en,
  output logic [`PC_W-1:0]           mem_rd_addr,
  output logic                       irq_request
);

  localparam logic [4*`NUM_SRC-1:0] SLOTS = `SRC_SLOTS;

  disp_state_e              state_reg, state_next;
  logic [2:0]               cnt_reg, cnt_next;
  logic [`NUM_SRC-1:0]      enable_reg, enable_next;
  logic [`NUM_SRC-1:0]      pending_reg, pending_next;
  logic                     global_irq_enable_reg, global_irq_enable_next;
  logic                     trap_reg, trap_next;
  logic                     push_valid_next, pop_req_next;
  logic [`PC_W-1:0]         push_addr_next;
  logic                     pc_load_next;
  logic [`PC_W-1:0]         pc_value_next;
  logic                     mem_rd_en_next;
  logic [`PC_W-1:0]         mem_rd_addr_next;
  logic [6:0]               vec_hi_reg, vec_hi_next;

  logic                     aw_held_reg, aw_held_next;
  logic [7:0]               aw_addr_reg, aw_addr_next;
  logic                     w_held_reg, w_held_next;
  logic [31:0]              w_data_reg, w_data_next;
  logic [3:0]               w_strb_reg, w_strb_next;
  logic                     bvalid_next;
  logic [1:0]               bresp_next;
  logic                     rvalid_next;
  logic [1:0]               rresp_next;
  logic [31:0]              rdata_next;

  logic [`NUM_SRC-1:0]      active;
  logic                     maskable_req;
  logic                     take_ack;
  logic [7:0]               vec_low;
  logic [6:0]               vec_page;
  logic                     wr_fire;
  logic [31:0]              wr_val;

  // combinational gating, so a fresh enable acts in the same cycle
  assign active       = enable_reg & pending_reg;
  assign maskable_req = (|active) & global_irq_enable_reg
                        & ~trap_reg;
  assign irq_request  = maskable_req & ~boot_exec;

  // trap opcode acknowledges regardless of mask; trap can nest on trap
  assign take_ack = (state_reg == ST_IDLE) & instr_start & ~instr_skipped
                    & ~boot_exec
                    & (trap_opcode | maskable_req);

  // arbitration: scan from lowest rank up so highest rank wins
  always_comb begin
    vec_low = `VEC_DEFAULT;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (active[i]) begin
        vec_low = {3'h7, SLOTS[4*i +: 4], 1'b0};
      end
    end
    if (trap_reg) begin
      vec_low = `VEC_TRAP;
    end
  end

  // dispatch at a block's last byte reads the following block's table
  always_comb begin
    if (dispatch_pc[7:0] == `PAGE_LAST) begin
      vec_page = dispatch_pc[14:8] + `PAGE_ONE;
    end else begin
      vec_page = dispatch_pc[14:8];
    end
  end

  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_val[8*b +: 8] = w_strb_reg[b] ? w_data_reg[8*b +: 8] : 8'h00;
    end
  end

  always_comb begin
    state_next       = state_reg;
    cnt_next         = cnt_reg;
    enable_next      = enable_reg;
    pending_next     = pending_reg;
    global_irq_enable_next = global_irq_enable_reg;
    trap_next        = trap_reg;
    push_valid_next  = 1'b0;
    push_addr_next   = push_addr;
    pop_req_next     = 1'b0;
    pc_load_next     = 1'b0;
    pc_value_next    = pc_value;
    mem_rd_en_next   = 1'b0;
    mem_rd_addr_next = mem_rd_addr;
    vec_hi_next      = vec_hi_reg;

    // software register writes; hardware sets below win over clears
    if (wr_fire) begin
      unique case (aw_addr_reg)
        `OFS_ENABLE: enable_next = wr_val[`NUM_SRC-1:0];
        `OFS_PENDING: pending_next = pending_reg & ~wr_val[`NUM_SRC-1:0];
        `OFS_PEND_SET: pending_next = pending_reg | wr_val[`NUM_SRC-1:0];
        `OFS_STATUS_WORD: begin
          if (w_strb_reg[0]) begin
            global_irq_enable_next = w_data_reg[`STAT_IRQ_EN_BIT];
          end
        end
        default: ;
      endcase
    end
    // events during boot still set pending; repeats merge and are lost
    pending_next = pending_next | src_event;

    if (clear_trap_pending_instruction) begin
      trap_next = 1'b0;
    end
    if (return_and_reenable_instruction) begin
      global_irq_enable_next = 1'b1;
      pop_req_next = 1'b1;
    end

    unique case (state_reg)
      ST_IDLE: begin
        if (take_ack) begin
          state_next      = ST_ACK;
          cnt_next        = 3'h0;
          push_valid_next = 1'b1;
          push_addr_next  = next_pc;
          if (trap_opcode) begin
            trap_next = 1'b1;
          end else begin
            global_irq_enable_next = 1'b0;
          end
        end else if (vector_dispatch_instruction) begin
          state_next       = ST_VEC_HI;
          mem_rd_en_next   = 1'b1;
          mem_rd_addr_next = {vec_page, vec_low};
        end
      end
      ST_ACK: begin
        cnt_next = cnt_reg + 3'h1;
        // load is registered: issue it early so it lands in the last busy cycle
        if (cnt_reg == `ACK_LAST - 3'h2) begin
          pc_load_next  = 1'b1;
          pc_value_next = `ENTRY_ADDR;
        end
        if (cnt_reg == `ACK_LAST - 3'h1) begin
          state_next = ST_IDLE;
        end
      end
      ST_VEC_HI: begin
        state_next       = ST_VEC_LO;
        mem_rd_en_next   = 1'b1;
        mem_rd_addr_next = mem_rd_addr + 15'h0001;
      end
      ST_VEC_LO: begin
        if (!mem_rd_en) begin
          state_next    = ST_IDLE;
          pc_load_next  = 1'b1;
          pc_value_next = {vec_hi_reg, mem_rd_data};
        end else begin
          vec_hi_next = mem_rd_data[6:0];
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= 3'h0;
      enable_reg  <= '0;
      pending_reg <= '0;
      global_irq_enable_reg <= 1'b0;
      trap_reg    <= 1'b0;
      push_valid  <= 1'b0;
      push_addr   <= '0;
      pop_req     <= 1'b0;
      pc_load     <= 1'b0;
      pc_value    <= '0;
      mem_rd_en   <= 1'b0;
      mem_rd_addr <= '0;
      vec_hi_reg  <= 7'h00;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      enable_reg  <= enable_next;
      pending_reg <= pending_next;
      global_irq_enable_reg <= global_irq_enable_next;
      trap_reg    <= trap_next;
      push_valid  <= push_valid_next;
      push_addr   <= push_addr_next;
      pop_req     <= pop_req_next;
      pc_load     <= pc_load_next;
      pc_value    <= pc_value_next;
      mem_rd_en   <= mem_rd_en_next;
      mem_rd_addr <= mem_rd_addr_next;
      vec_hi_reg  <= vec_hi_next;
    end
  end

  // busy covers only the six cycles in ST_ACK, not the acknowledge cycle taken in idle
  assign ack_busy = (state_reg == ST_ACK);

  // axi4-lite slave: address and data latched in either order
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = s_axi_bvalid;
    bresp_next   = s_axi_bresp;
    rvalid_next  = s_axi_rvalid;
    rresp_next   = s_axi_rresp;
    rdata_next   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      unique case (aw_addr_reg)
        `OFS_ENABLE, `OFS_PENDING, `OFS_PEND_SET,
        `OFS_STATUS_WORD: bresp_next = `RESP_OKAY;
        default: bresp_next = `RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = `RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `OFS_ENABLE: rdata_next[`NUM_SRC-1:0] = enable_reg;
        `OFS_PENDING: rdata_next[`NUM_SRC-1:0] = pending_reg;
        `OFS_PEND_SET: rdata_next[`NUM_SRC-1:0] = pending_reg;
        `OFS_STATUS_WORD: begin
          rdata_next[`STAT_IRQ_EN_BIT] = global_irq_enable_reg;
          rdata_next[`STAT_TRAP_BIT] = trap_reg;
          rdata_next[`STAT_BUSY_BIT] = (state_reg != ST_IDLE);
        end
        default: rresp_next = `RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else begin
      aw_held_reg  <= aw_held_next;
      aw_addr_reg  <= aw_addr_next;
      w_held_reg   <= w_held_next;
      w_data_reg   <= w_data_next;
      w_strb_reg   <= w_strb_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp  <= bresp_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rresp  <= rresp_next;
      s_axi_rdata  <= rdata_next;
    end
  end

endmodule : vectored_interrupt_dispatch

// ### dv/vid_checker.sv
// Purpose: port-level checks of acknowledge and dispatch timing
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   dispatch pc captured one cycle late to match the fetch
`timescale 1ns/100ps
`include "irq_dispatch_regs.svh"
module vid_checker
  import irq_dispatch_pkg::*;
(
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         instr_start,
  input wire logic         instr_skipped,
  input wire logic         boot_exec,
  input wire logic [14:0]  next_pc,
  input wire logic         return_and_reenable_instruction,
  input wire logic         vector_dispatch_instruction,
  input wire logic [14:0]  dispatch_pc,
  input wire logic [7:0]   mem_rd_data,
  input wire logic         ack_busy,
  input wire logic         push_valid,
  input wire logic [14:0]  push_addr,
  input wire logic         pop_req,
  input wire logic         pc_load,
  input wire logic [14:0]  pc_value,
  input wire logic         mem_rd_en,
  input wire logic [14:0]  mem_rd_addr
);
  logic [14:0] dpc_reg;
  logic [6:0]  page_x;
  always_ff @(posedge aclk) dpc_reg <= dispatch_pc;
  // last byte of a block moves the table to the next block
  assign page_x = (dpc_reg[7:0] == 8'hff) ? dpc_reg[14:8] + 7'h01
                                          : dpc_reg[14:8];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_ACK_ENTRY: assert property (push_valid |-> ##5
    (pc_load && pc_value == `ENTRY_ADDR)) else $error("entry load late");
  AST_ACK_BUSY: assert property (push_valid |->
    ack_busy [*6] ##1 !ack_busy) else $error("busy length wrong");
  AST_PUSH_ADDR: assert property (push_valid |->
    $past(instr_start) && push_addr == $past(next_pc))
    else $error("pushed address wrong");
  AST_ACK_SLOT: assert property (push_valid |->
    !$past(instr_skipped) && !$past(boot_exec)) else $error("ack in bad slot");
  AST_RET_POP: assert property (return_and_reenable_instruction |=>
    pop_req) else $error("no pop after return");
  AST_VEC_ADDR: assert property (vector_dispatch_instruction |=>
    mem_rd_en && mem_rd_addr[14:8] == page_x && mem_rd_addr[7:5] == 3'h7
    && !mem_rd_addr[0]) else $error("vector address wrong");
  AST_VEC_PAIR: assert property (vector_dispatch_instruction ##1 mem_rd_en
    |=> mem_rd_en && mem_rd_addr == $past(mem_rd_addr) + 15'h1)
    else $error("second vector fetch wrong");
  AST_VEC_LOAD: assert property (vector_dispatch_instruction |-> ##4
    pc_load && {1'b0, pc_value[14:8]} == ($past(mem_rd_data, 2) & 8'h7f)
    && pc_value[7:0] == $past(mem_rd_data)) else $error("vector load wrong");
  cover property (push_valid);
  cover property (vector_dispatch_instruction && dispatch_pc[7:0] == 8'hff);
  cover property (pop_req);
endmodule : vid_checker

bind vectored_interrupt_dispatch vid_checker u_chk (.aclk(aclk),
  .aresetn(aresetn), .instr_start(instr_start), .instr_skipped(instr_skipped),
  .boot_exec(boot_exec), .next_pc(next_pc),
  .return_and_reenable_instruction(return_and_reenable_instruction),
  .vector_dispatch_instruction(vector_dispatch_instruction),
  .dispatch_pc(dispatch_pc), .mem_rd_data(mem_rd_data), .ack_busy(ack_busy),
  .push_valid(push_valid), .push_addr(push_addr), .pop_req(pop_req),
  .pc_load(pc_load), .pc_value(pc_value), .mem_rd_en(mem_rd_en),
  .mem_rd_addr(mem_rd_addr));

// ### dv/prog_mem_model.sv
// Purpose: program memory holding the vector table
// Assumes: byte answer one cycle after a read strobe
// Notes:   content is a fixed mix of address bits
`timescale 1ns/100ps
module prog_mem_model (
  input wire logic         aclk,
  input wire logic         mem_rd_en,
  input wire logic [14:0]  mem_rd_addr,
  output logic [7:0]       mem_rd_data = 8'h5a
);
  // idle cycles toggle the bus so stale bytes never look valid
  always @(posedge aclk)
    mem_rd_data <= mem_rd_en ? mem_rd_addr[7:0] ^ {1'b0, mem_rd_addr[14:8]}
                             : ~mem_rd_data;
endmodule : prog_mem_model

// ### dv/vectored_interrupt_dispatch_bench.sv
// Purpose: self-checking bench with a reference model
// Assumes: axi-lite master tasks, core strobes from ctl bits
// Notes:   ctl = boot, skip, dispatch, return, clear, trap, start
`timescale 1ns/100ps
`include "irq_dispatch_regs.svh"
module vectored_interrupt_dispatch_bench
  import irq_dispatch_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic ack_busy, push_valid, pop_req, pc_load, mem_rd_en, irq_request;
  logic [7:0] awaddr = 0, araddr = 0, mem_rd_data, lb;
  logic [31:0] wdata = 0, rdata, r;
  logic [1:0] bresp, rresp, resp;
  logic [11:0] src_event = 0, en = 0, pend = 0;
  logic [6:0] ctl = 0;
  logic [14:0] next_pc = 0, dispatch_pc = 0, push_addr, pc_value, mem_rd_addr;
  logic [14:0] push_q, pc_q, d;
  logic [14:0] exp_q [$];
  logic global_irq_enable = 0, trap = 0;
  logic [15:0] rnd = 16'hc710;
  logic [7:0] lb_tab [12] = '{8'hfa, 8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hee,
                              8'hec, 8'hea, 8'he8, 8'he6, 8'he4, 8'he2};
  int n_mismatch = 0, checks = 0, n_push = 0, n_pop = 0, cyc = 0;
  int i, m, k, s;

  vectored_interrupt_dispatch u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .src_event(src_event),
    .instr_start(ctl[0]), .instr_skipped(ctl[5]), .boot_exec(ctl[6]),
    .next_pc(next_pc), .trap_opcode(ctl[1]),
    .clear_trap_pending_instruction(ctl[2]),
    .return_and_reenable_instruction(ctl[3]),
    .vector_dispatch_instruction(ctl[4]), .dispatch_pc(dispatch_pc),
    .mem_rd_data(mem_rd_data), .ack_busy(ack_busy), .push_valid(push_valid),
    .push_addr(push_addr), .pop_req(pop_req), .pc_load(pc_load),
    .pc_value(pc_value), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
    .irq_request(irq_request));
  prog_mem_model u_mem (.aclk(aclk), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));

  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (push_valid) begin
      push_q = push_addr;
      chk(push_addr, exp_q.size() ? exp_q.pop_front() : 32'hffff_ffff);
    end
    n_push += push_valid;
    n_pop += pop_req;
    if (pc_load) pc_q = pc_value;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  function automatic logic [15:0] nx(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : nx
  function automatic logic [7:0] memb(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]};
  endfunction : memb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (!bvalid);
    resp = bresp;
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
    r = rdata;
    resp = rresp;
    rready <= 0;
  endtask : rd
  task automatic pulse(input logic [6:0] v);
    @(posedge aclk);
    ctl <= v;
    @(posedge aclk);
    ctl <= 0;
  endtask : pulse
  task automatic stat_chk();
    rd(8'h08);
    chk(r, {30'h0, trap, global_irq_enable});
  endtask : stat_chk
  task automatic irq_chk();
    @(posedge aclk);
    chk(irq_request, |(en & pend) & global_irq_enable & ~trap);
  endtask : irq_chk
  task automatic disp(input logic [14:0] da, input logic [7:0] lo);
    logic [14:0] a;
    logic [7:0]  h;
    dispatch_pc <= da;
    pulse(7'h10);
    repeat (6) @(posedge aclk);
    a = {(da[7:0] == 8'hff) ? da[14:8] + 7'h01 : da[14:8], lo};
    h = memb(a);
    chk(pc_q, {h[6:0], memb(a + 15'h1)});
  endtask : disp
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00); chk(r, 0);
    rd(8'h04); chk(r, 0);
    stat_chk();
    rd(8'h10); chk(resp, `RESP_SLVERR);
    wr(8'h14, 0); chk(resp, `RESP_SLVERR);
    $display("test 1 done");
    rnd = nx(rnd);
    k = rnd % 12;
    wr(8'h0c, 32'h1 << k); pend[k] = 1;
    wr(8'h08, 1); global_irq_enable = 1;
    chk(resp, `RESP_OKAY);
    irq_chk();
    wr(8'h00, 32'h1 << k); en[k] = 1;
    irq_chk();
    src_event <= 12'h1 << ((k + 5) % 12);
    @(posedge aclk);
    src_event <= 0;
    pend[(k + 5) % 12] = 1;
    rd(8'h04); chk(r, pend);
    $display("test 2 done");
    // skipped slot, boot slot, then a normal slot
    for (m = 0; m < 3; m++) begin
      rnd = nx(rnd);
      next_pc <= rnd[14:0];
      if (m == 2) exp_q.push_back(rnd[14:0]);
      pulse(m == 0 ? 7'h21 : m == 1 ? 7'h41 : 7'h01);
      repeat (9) @(posedge aclk);
      chk(n_push, m / 2);
    end
    chk(push_q, rnd[14:0]);
    chk(pc_q, `ENTRY_ADDR);
    global_irq_enable = 0;
    stat_chk();
    wr(8'h08, 1); global_irq_enable = 1;
    stat_chk();
    wr(8'h08, 0); global_irq_enable = 0;
    pulse(7'h08); global_irq_enable = 1;
    repeat (2) @(posedge aclk);
    chk(n_pop, 1);
    stat_chk();
    irq_chk();
    $display("test 3 done");
    for (i = 0; i < 10; i++) begin
      rnd = nx(rnd);
      en = (i == 1) ? 12'h0 : rnd[11:0];
      rnd = nx(rnd);
      pend = rnd[11:0];
      wr(8'h00, en);
      wr(8'h04, 32'hfff);
      wr(8'h0c, pend);
      lb = 8'he0;
      for (s = 11; s >= 0; s--) if (en[s] & pend[s]) lb = lb_tab[s];
      rnd = nx(rnd);
      d = (i == 0) ? {rnd[14:8], 8'hff} : rnd[14:0];
      disp(d, lb);
    end
    $display("test 4 done");
    exp_q.push_back(next_pc);
    pulse(7'h03); trap = 1;
    repeat (9) @(posedge aclk);
    chk(n_push, 2);
    stat_chk();
    irq_chk();
    disp(rnd[14:0], 8'hfe);
    pulse(7'h04); trap = 0;
    stat_chk();
    irq_chk();
    chk(exp_q.size(), 0);
    $display("test 5 done");
    conclude();
  end
endmodule : vectored_interrupt_dispatch_bench
